/* interval_timer_cfg.svh */
// constants for the five-channel interval timer
`ifndef INTERVAL_TIMER_CFG_SVH
`define INTERVAL_TIMER_CFG_SVH
`define TMR_CLK_HZ        125000000
`define TMR_SLOW_TICK_NS  1000000
`define TMR_FAST_TICK_NS  333
`define TMR_SLOW_CYCLES   ((`TMR_SLOW_TICK_NS * 125) / 1000)
`define TMR_FAST_CYCLES   ((`TMR_FAST_TICK_NS * 125) / 1000)
`define TMR_FAST_CHANNEL  3
`define TMR_NUM_CHANNELS  5
`define TMR_ADDR_PAGE_LSB 12
`define TMR_OFF_CONTROL   12'h000
`define TMR_OFF_RELOAD    12'h004
`define TMR_OFF_SNAPSHOT  12'h008
`define TMR_OFF_COMMAND   12'h00C
`define TMR_OFF_IRQ_STAT  12'h010
`define TMR_OFF_IRQ_MASK  12'h014
`define TMR_BIT_IRQ_EN    0
`define TMR_BIT_STOP_ZERO 1
`define TMR_BIT_IRQ_STAT  2
`define TMR_BIT_RUNNING   4
`define TMR_CMD_STOP      2'h0
`define TMR_CMD_START     2'h1
`define TMR_CMD_RSVD      2'h2
`define TMR_CMD_LOAD_GO   2'h3
`endif

/* interval_timer_pkg.sv */
// types for the five-channel interval timer
package interval_timer_pkg;
	typedef struct packed {
		logic [15:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;
	typedef enum logic [1:0] {
		CH_IDLE = 2'b00,
		CH_RUN  = 2'b01
	} ch_state_t;
endpackage

/* tick_divider.sv */
// free-running tick strobe divider
`timescale 1ns/1ps
module tick_divider #(
	parameter int PERIOD = 125000
) (
	input  wire logic clk_sys_in,
	input  wire logic srst_in,
	output logic      tick_out
);
	localparam int W = $clog2(PERIOD + 1);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic         tick_d;
	logic         tick_q;

	// never restarted by a timer start
	always_comb begin
		tick_d = 1'b0;
		cnt_d = cnt_q + W'(1);
		if (cnt_q == W'(PERIOD - 1)) begin
			cnt_d = '0;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick_out = tick_q;

	a_tick_spacing: assert property (
		@(posedge clk_sys_in) disable iff (srst_in)
		tick_q |=> !tick_q)
		else $error("tick strobe longer than one cycle");
endmodule

/* interval_timer.sv */
// five-channel interval timer with register port
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "interval_timer_cfg.svh"
module interval_timer
	import interval_timer_pkg::*;
#(
	parameter int SLOW_CYCLES = `TMR_SLOW_CYCLES,
	parameter int FAST_CYCLES = `TMR_FAST_CYCLES,
	parameter int SLOW_WIDTH  = 16,
	parameter int FAST_WIDTH  = 24
) (
	input  wire logic        clk_sys_in,
	input  wire logic        srst_in,
	input  wire logic [15:0] addr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic      [31:0] rdata_out,
	output logic      [4:0]  timer_irq_out,
	output logic             irq_out
);
	localparam int N = `TMR_NUM_CHANNELS;

	reg_req_t req;
	assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

	logic slow_tick;
	logic fast_tick;

	tick_divider #(.PERIOD(SLOW_CYCLES)) u_slow (
		.clk_sys_in (clk_sys_in),
		.srst_in    (srst_in),
		.tick_out   (slow_tick)
	);
	tick_divider #(.PERIOD(FAST_CYCLES)) u_fast (
		.clk_sys_in (clk_sys_in),
		.srst_in    (srst_in),
		.tick_out   (fast_tick)
	);

	// channel page and register offset
	function automatic logic [3:0] page_of(input logic [15:0] a);
		page_of = a[`TMR_ADDR_PAGE_LSB +: 4];
	endfunction
	function automatic logic [11:0] off_of(input logic [15:0] a);
		off_of = a[`TMR_ADDR_PAGE_LSB-1:0];
	endfunction
	// width mask per channel
	function automatic logic [23:0] width_mask(input int ch);
		if (ch == `TMR_FAST_CHANNEL)
			width_mask = 24'((25'h1 << FAST_WIDTH) - 25'h1);
		else
			width_mask = 24'((25'h1 << SLOW_WIDTH) - 25'h1);
	endfunction

	logic [3:0]  pg;
	logic [11:0] off;
	assign pg = page_of(req.addr);
	assign off = off_of(req.addr);

	logic [N-1:0]  irq_en_q, irq_en_d;
	logic [N-1:0]  stop_zero_q, stop_zero_d;
	logic [N-1:0]  stat_q, stat_d;
	logic [N-1:0]  reload_pend_q, reload_pend_d;
	ch_state_t     state_q [N];
	ch_state_t     state_d [N];
	logic [23:0]   reload_q [N];
	logic [23:0]   reload_d [N];
	logic [23:0]   count_q [N];
	logic [23:0]   count_d [N];
	logic [N-1:0]  mask_q, mask_d;
	logic [31:0]   rdata_q, rdata_d;
	logic [N-1:0]  zero_evt;

	always_comb begin
		logic tk;
		logic sel;
		tk = 1'b0;
		sel = 1'b0;
		irq_en_d = irq_en_q;
		stop_zero_d = stop_zero_q;
		stat_d = stat_q;
		reload_pend_d = reload_pend_q;
		mask_d = mask_q;
		zero_evt = '0;
		rdata_d = 32'h0;
		for (int i = 0; i < N; i++) begin
			state_d[i] = state_q[i];
			reload_d[i] = reload_q[i];
			count_d[i] = count_q[i];
			tk = (i == `TMR_FAST_CHANNEL) ? fast_tick : slow_tick;
			sel = (pg == 4'(i));
			// counting
			if (state_q[i] == CH_RUN && tk) begin
				if (reload_pend_q[i]) begin
					count_d[i] = reload_q[i];
					reload_pend_d[i] = 1'b0;
				end else begin
					count_d[i] = (count_q[i] - 24'h1) & width_mask(i);
					if (count_q[i] == 24'h1) begin
						zero_evt[i] = 1'b1;
						if (stop_zero_q[i])
							state_d[i] = CH_IDLE;
						else
							reload_pend_d[i] = 1'b1;
					end
				end
			end
			// reads, latched this cycle
			if (req.rd && sel) begin
				case (off)
					`TMR_OFF_CONTROL: begin
						rdata_d[`TMR_BIT_IRQ_EN] = irq_en_q[i];
						rdata_d[`TMR_BIT_STOP_ZERO] = stop_zero_q[i];
						rdata_d[`TMR_BIT_IRQ_STAT] = stat_q[i];
						stat_d[i] = 1'b0;
					end
					`TMR_OFF_RELOAD:
						rdata_d[23:0] = reload_q[i] & width_mask(i);
					`TMR_OFF_SNAPSHOT:
						rdata_d[23:0] = count_q[i];
					`TMR_OFF_COMMAND:
						rdata_d[`TMR_BIT_RUNNING] =
							(state_q[i] == CH_RUN);
					default: rdata_d = 32'h0;
				endcase
			end
			// writes
			if (req.wr && sel) begin
				case (off)
					`TMR_OFF_CONTROL: begin
						irq_en_d[i] = req.wdata[`TMR_BIT_IRQ_EN];
						stop_zero_d[i] = req.wdata[`TMR_BIT_STOP_ZERO];
					end
					`TMR_OFF_RELOAD:
						reload_d[i] = req.wdata[23:0] & width_mask(i);
					`TMR_OFF_COMMAND: begin
						case (req.wdata[1:0])
							`TMR_CMD_STOP: state_d[i] = CH_IDLE;
							`TMR_CMD_START: state_d[i] = CH_RUN;
							`TMR_CMD_LOAD_GO: begin
								count_d[i] = reload_d[i];
								reload_pend_d[i] = 1'b0;
								state_d[i] = CH_RUN;
							end
							default: state_d[i] = state_q[i];
						endcase
					end
					default: state_d[i] = state_d[i];
				endcase
			end
			// set wins over read-clear
			if (zero_evt[i] && irq_en_q[i])
				stat_d[i] = 1'b1;
		end
		if (req.rd && pg == 4'(N)) begin
			if (off == `TMR_OFF_IRQ_STAT)
				rdata_d[N-1:0] = stat_q;
			else if (off == `TMR_OFF_IRQ_MASK)
				rdata_d[N-1:0] = mask_q;
		end
		if (req.wr && pg == 4'(N)) begin
			if (off == `TMR_OFF_IRQ_STAT)
				stat_d = stat_d & ~(req.wdata[N-1:0] & ~(zero_evt & irq_en_q));
			else if (off == `TMR_OFF_IRQ_MASK)
				mask_d = req.wdata[N-1:0];
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			irq_en_q <= '0;
			stop_zero_q <= '0;
			stat_q <= '0;
			reload_pend_q <= '0;
			mask_q <= '1;
			rdata_q <= 32'h0;
			for (int i = 0; i < N; i++) begin
				state_q[i] <= CH_IDLE;
				reload_q[i] <= 24'h0;
				count_q[i] <= 24'h0;
			end
		end else begin
			irq_en_q <= irq_en_d;
			stop_zero_q <= stop_zero_d;
			stat_q <= stat_d;
			reload_pend_q <= reload_pend_d;
			mask_q <= mask_d;
			rdata_q <= rdata_d;
			for (int i = 0; i < N; i++) begin
				state_q[i] <= state_d[i];
				reload_q[i] <= reload_d[i];
				count_q[i] <= count_d[i];
			end
		end
	end

	assign rdata_out = rdata_q;
	assign timer_irq_out = stat_q;
	assign irq_out = |(stat_q & mask_q);

	// interrupt status
	a_irq_needs_en: assert property (
		@(posedge clk_sys_in) disable iff (srst_in)
		$rose(stat_q[0]) |-> $past(irq_en_q[0]))
		else $error("irq without enable");
	a_stat_set: assert property (
		@(posedge clk_sys_in) disable iff (srst_in)
		(zero_evt[0] && irq_en_q[0]) |=> stat_q[0])
		else $error("zero count did not set status");
	a_irq_disabled: assert property (
		@(posedge clk_sys_in) disable iff (srst_in)
		(!irq_en_q[2] && !stat_q[2]) |=> !stat_q[2])
		else $error("status set while disabled");
	a_ctrl_rd_clr: assert property (
		@(posedge clk_sys_in) disable iff (srst_in)
		(req.rd && pg == 4'h0 && off == `TMR_OFF_CONTROL
		&& !zero_evt[0])
		|=> !stat_q[0])
		else $error("read did not clear status");
	a_ctrl_show: assert property (
		@(posedge clk_sys_in) disable iff (srst_in)
		(req.rd && pg == 4'h0 && off == `TMR_OFF_CONTROL)
		|=> rdata_q[`TMR_BIT_IRQ_STAT] == $past(stat_q[0]))
		else $error("status bit not shown");
	a_stat_w1c: assert property (
		@(posedge clk_sys_in) disable iff (srst_in)
		(req.wr && pg == 4'h5 && off == `TMR_OFF_IRQ_STAT
		&& req.wdata[0] && !zero_evt[0])
		|=> !stat_q[0])
		else $error("write one did not clear status");

	// counting
	a_stop_at_zero: assert property (
		@(posedge clk_sys_in) disable iff (srst_in)
		(zero_evt[0] && stop_zero_q[0] && !(req.wr && pg == 4'h0))
		|=> state_q[0] == CH_IDLE)
		else $error("no stop at zero");
	a_reload_next: assert property (
		@(posedge clk_sys_in) disable iff (srst_in)
		(reload_pend_q[2] && state_q[2] == CH_RUN && slow_tick
		&& !(req.wr && pg == 4'h2))
		|=> count_q[2] == $past(reload_q[2]))
		else $error("no reload");
	a_slow_step: assert property (
		@(posedge clk_sys_in) disable iff (srst_in)
		(state_q[0] == CH_RUN && slow_tick && !reload_pend_q[0]
		&& count_q[0] > 24'h1 && !(req.wr && pg == 4'h0))
		|=> count_q[0] == $past(count_q[0]) - 24'h1)
		else $error("slow channel step wrong");
	a_fast_step: assert property (
		@(posedge clk_sys_in) disable iff (srst_in)
		(state_q[3] == CH_RUN && fast_tick && !reload_pend_q[3]
		&& count_q[3] > 24'h1 && !(req.wr && pg == 4'h3))
		|=> count_q[3] == $past(count_q[3]) - 24'h1)
		else $error("fast channel step wrong");
	a_tick_only: assert property (
		@(posedge clk_sys_in) disable iff (srst_in)
		(state_q[3] == CH_RUN && !fast_tick && !(req.wr && pg == 4'h3))
		|=> $stable(count_q[3]))
		else $error("count moved without tick");
	a_slow_width: assert property (
		@(posedge clk_sys_in) disable iff (srst_in)
		count_q[0][23:16] == 8'h0)
		else $error("16-bit channel overflow");
	a_reload_mask: assert property (
		@(posedge clk_sys_in) disable iff (srst_in)
		reload_q[1][23:16] == 8'h0)
		else $error("16-bit reload holds upper bits");
	a_idle_holds: assert property (
		@(posedge clk_sys_in) disable iff (srst_in)
		(state_q[1] == CH_IDLE && !req.wr)
		|=> $stable(count_q[1]))
		else $error("idle channel counted");
	a_load_start: assert property (
		@(posedge clk_sys_in) disable iff (srst_in)
		(req.wr && pg == 4'h0 && off == `TMR_OFF_COMMAND
		&& req.wdata[1:0] == `TMR_CMD_LOAD_GO)
		|=> state_q[0] == CH_RUN)
		else $error("load+start failed");
	a_cmd_stop: assert property (
		@(posedge clk_sys_in) disable iff (srst_in)
		(req.wr && pg == 4'h2 && off == `TMR_OFF_COMMAND
		&& req.wdata[1:0] == `TMR_CMD_STOP)
		|=> state_q[2] == CH_IDLE)
		else $error("stop command failed");
	a_cmd_start: assert property (
		@(posedge clk_sys_in) disable iff (srst_in)
		(req.wr && pg == 4'h2 && off == `TMR_OFF_COMMAND
		&& req.wdata[1:0] == `TMR_CMD_START)
		|=> state_q[2] == CH_RUN)
		else $error("start command failed");
	a_cmd_rsvd: assert property (
		@(posedge clk_sys_in) disable iff (srst_in)
		(req.wr && pg == 4'h2 && off == `TMR_OFF_COMMAND
		&& req.wdata[1:0] == `TMR_CMD_RSVD && !zero_evt[2])
		|=> state_q[2] == $past(state_q[2]))
		else $error("reserved command acted");

	// register reads
	a_rdata_zero: assert property (
		@(posedge clk_sys_in) disable iff (srst_in)
		!req.rd |=> rdata_q == 32'h0)
		else $error("read data outside read cycle");
	a_snap_value: assert property (
		@(posedge clk_sys_in) disable iff (srst_in)
		(req.rd && pg == 4'h3 && off == `TMR_OFF_SNAPSHOT)
		|=> rdata_q[23:0] == $past(count_q[3]))
		else $error("bad snapshot");
	a_snap_upper: assert property (
		@(posedge clk_sys_in) disable iff (srst_in)
		(req.rd && pg == 4'h0 && off == `TMR_OFF_SNAPSHOT)
		|=> rdata_q[31:16] == 16'h0)
		else $error("16-bit snapshot upper bits set");
	a_snap_hold: assert property (
		@(posedge clk_sys_in) disable iff (srst_in)
		(req.rd && pg == 4'h3 && state_q[3] == CH_RUN
		&& !reload_pend_q[3] && count_q[3] > 24'h1)
		|=> count_q[3] == $past(count_q[3])
			- ($past(fast_tick) ? 24'h1 : 24'h0))
		else $error("read disturbed count");
	a_run_flag: assert property (
		@(posedge clk_sys_in) disable iff (srst_in)
		(req.rd && pg == 4'h2 && off == `TMR_OFF_COMMAND)
		|=> rdata_q[`TMR_BIT_RUNNING] == ($past(state_q[2]) == CH_RUN))
		else $error("running flag wrong");
endmodule

/* interval_timer_bench.sv */
// self-checking bench for the five-channel interval timer
`timescale 1ns/1ps
`include "interval_timer_cfg.svh"
module interval_timer_bench;
	localparam int SLOW = 20;
	localparam int FAST = 5;
	logic        clk_sys_in = 1'b0;
	logic        srst_in    = 1'b1;
	logic [15:0] addr_in    = 16'h0000;
	logic [31:0] wdata_in   = 32'h00000000;
	logic        wr_in      = 1'b0;
	logic        rd_in      = 1'b0;
	logic [31:0] rdata_out;
	logic [4:0]  timer_irq_out;
	logic        irq_out;
	int          bad_count  = 0;
	int          n_tests    = 0;
	int          cycles     = 0;
	logic [31:0] v;
	logic [31:0] w;
	int          n;

	interval_timer #(.SLOW_CYCLES(SLOW), .FAST_CYCLES(FAST)) interval_timer_i (
		.clk_sys_in   (clk_sys_in),
		.srst_in      (srst_in),
		.addr_in      (addr_in),
		.wdata_in     (wdata_in),
		.wr_in        (wr_in),
		.rd_in        (rd_in),
		.rdata_out    (rdata_out),
		.timer_irq_out(timer_irq_out),
		.irq_out      (irq_out)
	);

	always #4 clk_sys_in = ~clk_sys_in;

	// hang guard, well above the few hundred cycles the tests need
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 6000) begin
			bad_count++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [15:0] ra(input logic [3:0] ch,
		input logic [11:0] off);
		ra = {ch, off};
	endfunction

	task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge clk_sys_in);
		wr_in    <= 1'b0;
	endtask

	task automatic rd_reg(input logic [15:0] a, output logic [31:0] d);
		@(posedge clk_sys_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clk_sys_in);
		rd_in   <= 1'b0;
		#1 d = rdata_out;
	endtask

	// cycles until the channel interrupt shows, bounded
	task automatic wait_irq(input int ch, output int cnt);
		cnt = 0;
		while (timer_irq_out[ch] !== 1'b1 && cnt < 400) begin
			@(posedge clk_sys_in);
			#1;
			cnt++;
		end
	endtask

	task automatic t_reset();
		for (int c = 0; c < 5; c++) begin
			rd_reg(ra(4'(c), `TMR_OFF_CONTROL), v);
			chk(v, 32'h00000000);
			rd_reg(ra(4'(c), `TMR_OFF_COMMAND), v);
			chk(v, 32'h00000000);
		end
		rd_reg(ra(4'h5, `TMR_OFF_IRQ_MASK), v);
		chk(v, 32'h0000001F);
		@(posedge clk_sys_in);
		#1 chk(rdata_out, 32'h00000000);
		wr_reg(16'h6000, 32'hFFFFFFFF);
		rd_reg(16'h6000, v);
		chk(v, 32'h00000000);
		chk({27'h0, timer_irq_out}, 32'h00000000);
		$display("t_reset done");
	endtask

	task automatic t_stop_zero();
		wr_reg(ra(4'h0, `TMR_OFF_RELOAD), 32'h00000003);
		wr_reg(ra(4'h0, `TMR_OFF_CONTROL), 32'h00000003);
		wr_reg(ra(4'h0, `TMR_OFF_COMMAND), 32'h00000003);
		wait_irq(0, n);
		chk(32'(n >= 2 * SLOW && n <= 3 * SLOW + 4), 32'h1);
		@(posedge clk_sys_in);
		#1 chk({31'h0, irq_out}, 32'h1);
		rd_reg(ra(4'h5, `TMR_OFF_IRQ_STAT), v);
		chk(v, 32'h00000001);
		repeat (3 * SLOW) @(posedge clk_sys_in);
		rd_reg(ra(4'h0, `TMR_OFF_SNAPSHOT), v);
		chk(v, 32'h00000000);
		rd_reg(ra(4'h0, `TMR_OFF_COMMAND), v);
		chk(v, 32'h00000000);
		wr_reg(ra(4'h5, `TMR_OFF_IRQ_MASK), 32'h00000000);
		@(posedge clk_sys_in);
		#1 chk({31'h0, irq_out}, 32'h0);
		wr_reg(ra(4'h5, `TMR_OFF_IRQ_MASK), 32'h0000001F);
		wr_reg(ra(4'h5, `TMR_OFF_IRQ_STAT), 32'h00000001);
		@(posedge clk_sys_in);
		#1 chk({27'h0, timer_irq_out}, 32'h00000000);
		wr_reg(ra(4'h0, `TMR_OFF_COMMAND), 32'h00000003);
		wait_irq(0, n);
		chk(32'(n <= 3 * SLOW + 4), 32'h1);
		rd_reg(ra(4'h0, `TMR_OFF_CONTROL), v);
		chk(v, 32'h00000007);
		rd_reg(ra(4'h0, `TMR_OFF_CONTROL), v);
		chk(v, 32'h00000003);
		chk({27'h0, timer_irq_out}, 32'h00000000);
		$display("t_stop_zero done");
	endtask

	task automatic t_reload();
		wr_reg(ra(4'h2, `TMR_OFF_RELOAD), 32'h00000002);
		wr_reg(ra(4'h2, `TMR_OFF_CONTROL), 32'h00000000);
		wr_reg(ra(4'h2, `TMR_OFF_COMMAND), 32'h00000003);
		repeat (7 * SLOW) @(posedge clk_sys_in);
		chk({27'h0, timer_irq_out}, 32'h00000000);
		rd_reg(ra(4'h2, `TMR_OFF_COMMAND), v);
		chk(v, 32'h00000010);
		rd_reg(ra(4'h2, `TMR_OFF_SNAPSHOT), v);
		chk(32'(v < 32'h3), 32'h1);
		wr_reg(ra(4'h2, `TMR_OFF_COMMAND), 32'h00000000);
		rd_reg(ra(4'h2, `TMR_OFF_SNAPSHOT), v);
		repeat (3 * SLOW) @(posedge clk_sys_in);
		rd_reg(ra(4'h2, `TMR_OFF_SNAPSHOT), w);
		chk(w, v);
		wr_reg(ra(4'h2, `TMR_OFF_COMMAND), 32'h00000002);
		rd_reg(ra(4'h2, `TMR_OFF_COMMAND), v);
		chk(v, 32'h00000000);
		wr_reg(ra(4'h2, `TMR_OFF_COMMAND), 32'h00000001);
		rd_reg(ra(4'h2, `TMR_OFF_COMMAND), v);
		chk(v, 32'h00000010);
		$display("t_reload done");
	endtask

	task automatic t_wide();
		wr_reg(ra(4'h1, `TMR_OFF_RELOAD), 32'h00ABCDEF);
		rd_reg(ra(4'h1, `TMR_OFF_RELOAD), v);
		chk(v, 32'h0000CDEF);
		wr_reg(ra(4'h3, `TMR_OFF_RELOAD), 32'h00ABCDEF);
		rd_reg(ra(4'h3, `TMR_OFF_RELOAD), v);
		chk(v, 32'h00ABCDEF);
		wr_reg(ra(4'h3, `TMR_OFF_CONTROL), 32'h00000002);
		wr_reg(ra(4'h3, `TMR_OFF_COMMAND), 32'h00000003);
		rd_reg(ra(4'h3, `TMR_OFF_SNAPSHOT), v);
		repeat (40) @(posedge clk_sys_in);
		rd_reg(ra(4'h3, `TMR_OFF_SNAPSHOT), w);
		// reads taken 42 cycles apart: 8 or 9 fast ticks
		chk(32'((v - w) >= 8 && (v - w) <= 9), 32'h1);
		chk(32'(v <= 32'h00ABCDEF), 32'h1);
		rd_reg(ra(4'h3, `TMR_OFF_COMMAND), v);
		chk(v, 32'h00000010);
		$display("t_wide done");
	endtask

	initial begin
		repeat (16) @(posedge clk_sys_in);
		srst_in <= 1'b0;
		t_reset();
		t_stop_zero();
		t_reload();
		t_wide();
		stop_test();
	end
endmodule
